// ===== psa_core.sv
// program counter, return stack, table read, alu and status flags
module psa_core #(
	parameter int DEPTH = 5
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// program memory fetch port
	output logic [10:0] rom_addr_out,
	input wire logic [13:0] rom_data_in,
	// decoded instruction from the decoder
	input wire psa_pkg::psa_instr_s instr_in,
	output logic instr_take_out,
	// interrupt entry request
	input wire logic irq_req_in,
	output logic irq_ack_out,
	// file plane operand and write-back
	input wire logic [7:0] file_rd_data_in,
	output logic file_wr_out,
	output logic [6:0] file_wr_addr_out,
	output logic [7:0] file_wr_data_out,
	output logic [7:0] status_out,
	// table pointer registers
	input wire logic [2:0] rom_pointer_upper_in,
	input wire logic [7:0] rom_pointer_lower_in,
	// system events and supply monitor
	input wire logic low_supply_in,
	input wire logic [1:0] config_word_lvd_in,
	output logic [1:0] lvd_threshold_out,
	input wire logic watchdog_expiry_in,
	input wire logic power_on_reset_in,
	input wire logic low_voltage_reset_in,
	// observation
	output logic [7:0] acc_out,
	output logic [10:0] pc_out,
	output logic [2:0] page_out,
	output logic sram_bank_select_out,
	output logic [2:0] stack_count_out
);
	psa_pkg::psa_state_e state;
	psa_pkg::psa_state_e next_state;
	logic [10:0] pc;
	logic [10:0] next_pc;
	logic [7:0] acc;
	logic [7:0] status;
	logic [10:0] stack_mem [DEPTH];
	logic [2:0] sp;
	logic [2:0] count;
	logic push;
	logic pop;
	logic [10:0] stack_top;
	logic [2:0] sp_dec;
	logic [2:0] sp_inc;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] opnd;
	logic [7:0] result;
	logic res_c;
	logic res_dc;
	logic [10:0] tbl_addr;
	logic exec;
	logic pcl_write;
	logic status_write;

	// a pending interrupt displaces the instruction, which is offered again on return
	assign exec = (state == psa_pkg::PSA_ST_EXEC) && !irq_req_in;
	assign instr_take_out = exec;
	assign irq_ack_out = (state == psa_pkg::PSA_ST_EXEC) && irq_req_in;
	assign opnd = instr_in.use_literal ? instr_in.literal : file_rd_data_in;
	assign pcl_write = exec && instr_in.write_file
		&& (instr_in.file_addr == psa_pkg::COUNTER_LOW_ADDR);
	assign status_write = exec && instr_in.write_file
		&& (instr_in.file_addr == psa_pkg::STATUS_ADDR);
	assign tbl_addr = {rom_pointer_upper_in, rom_pointer_lower_in};

	// stack pointer arithmetic wraps at DEPTH so a full push drops the oldest
	assign sp_inc = (sp == 3'(DEPTH - 1)) ? 3'h0 : sp + 3'h1;
	assign sp_dec = (sp == 3'h0) ? 3'(DEPTH - 1) : sp - 3'h1;
	// a pop reads the entry just below the pointer
	assign stack_top = stack_mem[sp_dec];
	assign push = irq_ack_out
		|| (exec && instr_in.flow == psa_pkg::PSA_PC_CALL);
	assign pop = exec && (instr_in.flow == psa_pkg::PSA_PC_RET
		|| instr_in.flow == psa_pkg::PSA_PC_IRET
		|| instr_in.flow == psa_pkg::PSA_PC_LRET);

	// alu
	// rotates and logic ops leave nibble carry as it was
	always_comb begin
		sum = 9'h000;
		nib = 5'h00;
		result = 8'h00;
		res_c = status[psa_pkg::BIT_C];
		res_dc = status[psa_pkg::BIT_DC];
		case (instr_in.op)
			psa_pkg::PSA_OP_ADD: begin
				sum = {1'b0, acc} + {1'b0, opnd};
				nib = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
				result = sum[7:0];
				res_c = sum[8];
				res_dc = nib[4];
			end
			psa_pkg::PSA_OP_SUB: begin
				// carry out of f + ~w + 1 is the inverted borrow
				sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
				nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				result = sum[7:0];
				res_c = sum[8];
				res_dc = nib[4];
			end
			psa_pkg::PSA_OP_AND: result = acc & opnd;
			psa_pkg::PSA_OP_OR: result = acc | opnd;
			psa_pkg::PSA_OP_XOR: result = acc ^ opnd;
			psa_pkg::PSA_OP_RLC: begin
				result = {opnd[6:0], status[psa_pkg::BIT_C]};
				res_c = opnd[7];
			end
			psa_pkg::PSA_OP_RRC: begin
				result = {status[psa_pkg::BIT_C], opnd[7:1]};
				res_c = opnd[0];
			end
			psa_pkg::PSA_OP_MOV: result = opnd;
			psa_pkg::PSA_OP_COM: result = ~opnd;
			psa_pkg::PSA_OP_INC: result = opnd + 8'h01;
			psa_pkg::PSA_OP_DEC: result = opnd - 8'h01;
			default: result = acc;
		endcase
	end

	// counter selection
	always_comb begin
		next_pc = pc;
		next_state = state;
		case (state)
			psa_pkg::PSA_ST_FETCH: next_state = psa_pkg::PSA_ST_EXEC;
			psa_pkg::PSA_ST_EXEC: begin
				next_pc = pc + 11'h001;
				if (irq_req_in) begin
					next_pc = psa_pkg::IRQ_VECTOR;
					next_state = psa_pkg::PSA_ST_FLUSH;
				end else begin
					case (instr_in.flow)
						psa_pkg::PSA_PC_JUMP, psa_pkg::PSA_PC_CALL: begin
							next_pc = instr_in.target;
							next_state = psa_pkg::PSA_ST_FLUSH;
						end
						psa_pkg::PSA_PC_RET, psa_pkg::PSA_PC_IRET, psa_pkg::PSA_PC_LRET: begin
							next_pc = stack_top;
							next_state = psa_pkg::PSA_ST_FLUSH;
						end
						psa_pkg::PSA_PC_SKIP: begin
							next_pc = pc + 11'h002;
							next_state = psa_pkg::PSA_ST_FLUSH;
						end
						// counter already stepped; the pointer owns the fetch port next cycle
						psa_pkg::PSA_PC_TBL_LO, psa_pkg::PSA_PC_TBL_HI:
							next_state = psa_pkg::PSA_ST_TABLE;
						default: begin
							if (pcl_write) begin
								next_pc = {pc[10:8], result};
								next_state = psa_pkg::PSA_ST_FLUSH;
							end
						end
					endcase
				end
			end
			psa_pkg::PSA_ST_FLUSH: next_state = psa_pkg::PSA_ST_EXEC;
			psa_pkg::PSA_ST_TABLE: next_state = psa_pkg::PSA_ST_EXEC;
			default: next_state = psa_pkg::PSA_ST_FETCH;
		endcase
	end

	// table cycle borrows the fetch port for one cycle
	assign rom_addr_out = (state == psa_pkg::PSA_ST_TABLE) ? tbl_addr : pc;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= psa_pkg::PSA_ST_FETCH;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pc <= psa_pkg::RESET_VECTOR;
		end else begin
			pc <= next_pc;
		end
	end

	// table read type remembered across the extra cycle
	logic tbl_kind;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tbl_kind <= 1'b0;
		end else if (exec) begin
			tbl_kind <= (instr_in.flow == psa_pkg::PSA_PC_TBL_HI);
		end
	end

	// accumulator
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc <= 8'h00;
		end else if (state == psa_pkg::PSA_ST_TABLE) begin
			acc <= tbl_kind ? {2'b00, rom_data_in[13:8]} : rom_data_in[7:0];
		end else if (exec && instr_in.flow == psa_pkg::PSA_PC_LRET) begin
			acc <= instr_in.literal;
		end else if (exec && instr_in.write_acc) begin
			acc <= result;
		end
	end

	// return stack, contents not reset
	// interrupt entry saves the address of the displaced instruction
	always_ff @(posedge clk_in) begin
		if (push) begin
			stack_mem[sp] <= irq_ack_out ? pc : pc + 11'h001;
		end
	end

	// pointer marks the next free slot; a pop on empty still moves it, content is stale
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sp <= 3'h0;
		end else if (push) begin
			sp <= sp_inc;
		end else if (pop) begin
			sp <= sp_dec;
		end
	end

	// occupancy saturates at the depth, an overwritten entry is gone for good
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count <= 3'h0;
		end else if (push) begin
			if (count != 3'(DEPTH)) begin
				count <= count + 3'h1;
			end
		end else if (pop) begin
			if (count != 3'h0) begin
				count <= count - 3'h1;
			end
		end
	end

	// status register
	logic [7:0] next_status;
	always_comb begin
		next_status = status;
		if (status_write) begin
			next_status = (status & ~psa_pkg::STATUS_WMASK)
				| (result & psa_pkg::STATUS_WMASK);
		end
		if (exec && instr_in.flags != psa_pkg::PSA_FL_NONE) begin
			// operation flags win over a direct write
			next_status[psa_pkg::BIT_Z] = (result == 8'h00);
			if (instr_in.flags == psa_pkg::PSA_FL_ZC || instr_in.flags == psa_pkg::PSA_FL_ALL) begin
				next_status[psa_pkg::BIT_C] = res_c;
			end
			if (instr_in.flags == psa_pkg::PSA_FL_ALL) begin
				next_status[psa_pkg::BIT_DC] = res_dc;
			end
		end
		if ((exec && instr_in.watchdog_kick) || power_on_reset_in || low_voltage_reset_in) begin
			next_status[psa_pkg::BIT_PD] = 1'b0;
			next_status[psa_pkg::BIT_TO] = 1'b0;
		end
		// power-down set by sleep wins over a same-cycle clear
		if (exec && instr_in.sleep) begin
			next_status[psa_pkg::BIT_PD] = 1'b1;
			next_status[psa_pkg::BIT_TO] = 1'b0;
		end
		// timeout event wins over a same-cycle clear
		if (watchdog_expiry_in) begin
			next_status[psa_pkg::BIT_TO] = 1'b1;
		end
		// supply level copied every cycle, software writes never reach it
		next_status[psa_pkg::BIT_LSF] = low_supply_in;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status <= psa_pkg::STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// file write-back of alu result
	// status lives here, so its writes never leave the block
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			file_wr_out <= 1'b0;
			file_wr_addr_out <= 7'h00;
			file_wr_data_out <= 8'h00;
		end else begin
			file_wr_out <= exec && instr_in.write_file && !status_write;
			file_wr_addr_out <= instr_in.file_addr;
			file_wr_data_out <= result;
		end
	end

	assign status_out = status;
	assign acc_out = acc;
	assign pc_out = pc;
	assign page_out = pc[10:8];
	assign sram_bank_select_out = status[psa_pkg::BIT_BANK];
	assign stack_count_out = count;

	// threshold code only passes on to the supply comparator, which sits outside
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lvd_threshold_out <= 2'b00;
		end else begin
			lvd_threshold_out <= config_word_lvd_in;
		end
	end
endmodule

// ===== psa_core_checker.sv
// concurrent checks on the sequencer, stack and status core
module psa_core_checker #(
	parameter int DEPTH = 5
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// instruction and events
	input wire psa_pkg::psa_instr_s instr_in,
	input wire logic instr_take_out,
	input wire logic irq_ack_out,
	input wire logic [7:0] file_rd_data_in,
	input wire logic low_supply_in,
	// observed state
	input wire logic [7:0] status_out,
	input wire logic [7:0] acc_out,
	input wire logic [10:0] pc_out,
	input wire logic [2:0] page_out,
	input wire logic sram_bank_select_out,
	input wire logic [2:0] stack_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);
	logic [7:0] opnd;
	logic [4:0] nib;
	logic take_alu;
	assign opnd = instr_in.use_literal ? instr_in.literal : file_rd_data_in;
	assign nib = {1'b0, acc_out[3:0]} + {1'b0, opnd[3:0]};
	assign take_alu = instr_take_out && instr_in.flags == psa_pkg::PSA_FL_ALL;
	logic [7:0] add_res;
	assign add_res = acc_out + opnd;
	sequence s_branch;
		instr_take_out && instr_in.flow inside {psa_pkg::PSA_PC_JUMP, psa_pkg::PSA_PC_CALL,
			psa_pkg::PSA_PC_RET, psa_pkg::PSA_PC_IRET, psa_pkg::PSA_PC_LRET};
	endsequence
	sequence s_pop;
		instr_take_out && stack_count_out != 3'd0 && instr_in.flow inside {psa_pkg::PSA_PC_RET,
			psa_pkg::PSA_PC_IRET, psa_pkg::PSA_PC_LRET};
	endsequence
	property p_seq;
		instr_take_out && instr_in.flow == psa_pkg::PSA_PC_SEQ
			&& !(instr_in.write_file && instr_in.file_addr == 7'h02)
			|=> pc_out == $past(pc_out) + 11'h1;
	endproperty
	property p_load;
		instr_take_out && instr_in.flow inside {psa_pkg::PSA_PC_JUMP, psa_pkg::PSA_PC_CALL}
			|=> pc_out == $past(instr_in.target);
	endproperty
	property p_flush;
		s_branch |=> !instr_take_out;
	endproperty
	property p_irq;
		irq_ack_out |=> pc_out == 11'h001 && !instr_take_out;
	endproperty
	property p_push;
		instr_take_out && instr_in.flow == psa_pkg::PSA_PC_CALL && stack_count_out < 3'(DEPTH)
			|=> stack_count_out == $past(stack_count_out) + 3'd1;
	endproperty
	property p_pop;
		s_pop |=> stack_count_out == $past(stack_count_out) - 3'd1;
	endproperty
	property p_page_keep;
		instr_take_out && instr_in.write_file && instr_in.file_addr == psa_pkg::COUNTER_LOW_ADDR
			|=> pc_out[10:8] == $past(pc_out[10:8]);
	endproperty
	property p_page;
		page_out == pc_out[10:8];
	endproperty
	property p_bank;
		sram_bank_select_out == status_out[5];
	endproperty
	property p_lsf;
		$past(rstn_in) |-> status_out[7] == $past(low_supply_in);
	endproperty
	property p_dc;
		take_alu && instr_in.op == psa_pkg::PSA_OP_ADD |=> status_out[1] == $past(nib[4]);
	endproperty
	property p_sub;
		take_alu && instr_in.op == psa_pkg::PSA_OP_SUB && opnd == acc_out
			|=> status_out[2:0] == 3'b111;
	endproperty
	sequence s_status_add;
		take_alu && instr_in.op == psa_pkg::PSA_OP_ADD && instr_in.write_file
			&& instr_in.file_addr == psa_pkg::STATUS_ADDR;
	endsequence
	property p_guard;
		s_status_add |=> status_out[2] == ($past(add_res) == 8'h00);
	endproperty
	property p_bank_write;
		instr_take_out && instr_in.op == psa_pkg::PSA_OP_MOV && instr_in.write_file
			&& instr_in.file_addr == psa_pkg::STATUS_ADDR
			|=> sram_bank_select_out == $past(opnd[5]);
	endproperty
	property p_table;
		instr_take_out && instr_in.flow inside {psa_pkg::PSA_PC_TBL_LO, psa_pkg::PSA_PC_TBL_HI}
			|=> !instr_take_out;
	endproperty
	property p_irq_push;
		irq_ack_out && stack_count_out < 3'(DEPTH)
			|=> stack_count_out == $past(stack_count_out) + 3'd1;
	endproperty
	a_guard: assert property (p_guard) else $error("status write beat operation flags");
	a_bank_write: assert property (p_bank_write) else $error("bank bit not written");
	a_table: assert property (p_table) else $error("table read took no extra cycle");
	a_irq_push: assert property (p_irq_push) else $error("interrupt did not push");
	a_seq: assert property (p_seq) else $error("counter did not step by one");
	a_load: assert property (p_load) else $error("branch target not loaded");
	a_flush: assert property (p_flush) else $error("no flush after branch");
	a_irq: assert property (p_irq) else $error("interrupt vector wrong");
	a_push: assert property (p_push) else $error("call did not push");
	a_pop: assert property (p_pop) else $error("return did not pop");
	a_page_keep: assert property (p_page_keep) else $error("page bits changed");
	a_page: assert property (p_page) else $error("page output wrong");
	a_bank: assert property (p_bank) else $error("bank select wrong");
	a_lsf: assert property (p_lsf) else $error("low supply flag stale");
	a_dc: assert property (p_dc) else $error("nibble carry wrong on add");
	a_sub: assert property (p_sub) else $error("borrow flags wrong");
endmodule

bind psa_core psa_core_checker #(.DEPTH(DEPTH)) u_psa_chk (
	.clk_in(clk_in),
	.rstn_in(rstn_in),
	.instr_in(instr_in),
	.instr_take_out(instr_take_out),
	.irq_ack_out(irq_ack_out),
	.file_rd_data_in(file_rd_data_in),
	.low_supply_in(low_supply_in),
	.status_out(status_out),
	.acc_out(acc_out),
	.pc_out(pc_out),
	.page_out(page_out),
	.sram_bank_select_out(sram_bank_select_out),
	.stack_count_out(stack_count_out)
);

// ===== psa_pkg.sv
// shared constants and types for the sequencer, stack and status block
package psa_pkg;
	localparam int PC_W = 11;
	localparam int WORD_W = 14;
	localparam int DATA_W = 8;
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [10:0] IRQ_VECTOR = 11'h001;
	localparam logic [6:0] STATUS_ADDR = 7'h03;
	localparam logic [6:0] COUNTER_LOW_ADDR = 7'h02;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int BIT_C = 0;
	localparam int BIT_DC = 1;
	localparam int BIT_Z = 2;
	localparam int BIT_PD = 3;
	localparam int BIT_TO = 4;
	localparam int BIT_BANK = 5;
	localparam int BIT_SPARE = 6;
	localparam int BIT_LSF = 7;
	localparam logic [7:0] STATUS_WMASK = 8'h67;

	typedef enum logic [3:0] {
		PSA_OP_NONE = 4'h0,
		PSA_OP_ADD = 4'h1,
		PSA_OP_SUB = 4'h2,
		PSA_OP_AND = 4'h3,
		PSA_OP_OR = 4'h4,
		PSA_OP_XOR = 4'h5,
		PSA_OP_RLC = 4'h6,
		PSA_OP_RRC = 4'h7,
		PSA_OP_MOV = 4'h8,
		PSA_OP_COM = 4'h9,
		PSA_OP_INC = 4'ha,
		PSA_OP_DEC = 4'hb
	} psa_alu_e;

	typedef enum logic [2:0] {
		PSA_FL_NONE = 3'h0,
		PSA_FL_Z = 3'h1,
		PSA_FL_ZC = 3'h2,
		PSA_FL_ALL = 3'h3
	} psa_flags_e;

	typedef enum logic [3:0] {
		PSA_PC_SEQ = 4'h0,
		PSA_PC_JUMP = 4'h1,
		PSA_PC_CALL = 4'h2,
		PSA_PC_RET = 4'h3,
		PSA_PC_IRET = 4'h4,
		PSA_PC_LRET = 4'h5,
		PSA_PC_SKIP = 4'h6,
		PSA_PC_TBL_LO = 4'h7,
		PSA_PC_TBL_HI = 4'h8
	} psa_flow_e;

	typedef enum logic [1:0] {
		PSA_ST_FETCH = 2'b00,
		PSA_ST_EXEC = 2'b01,
		PSA_ST_FLUSH = 2'b10,
		PSA_ST_TABLE = 2'b11
	} psa_state_e;

	// one decoded instruction as handed in by the decoder
	typedef struct packed {
		psa_flow_e flow;
		psa_alu_e op;
		psa_flags_e flags;
		logic use_literal;
		logic [7:0] literal;
		logic [10:0] target;
		logic write_acc;
		logic write_file;
		logic [6:0] file_addr;
		logic watchdog_kick;
		logic sleep;
	} psa_instr_s;
endpackage

// ===== psa_rom.sv
// program memory model feeding 14-bit words to the fetch port
module psa_rom (
	// fetch port
	input wire logic [10:0] addr_in,
	output logic [13:0] data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [13:0] mem [0:2047];
	initial begin
		for (int a = 0; a < 2048; a++) begin
			mem[a] = 14'(a * 37 + 14'h1986);
		end
	end
	// combinational read, the core samples it in the same cycle
	assign data_out = mem[addr_in];
endmodule

// ===== test_pc_stack_alu_status.sv
// self-checking bench for the sequencer, stack and status core
module test_pc_stack_alu_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, rstn_in, take, irq_req, irq_ack, file_wr, lsup, wdx, por, lvr, bank;
	logic [13:0] rom_data;
	logic [10:0] rom_addr, pc;
	logic [7:0] wr_data, status, acc, plo, frd;
	logic [6:0] wr_addr;
	logic [2:0] page, cnt, pup;
	logic [1:0] cfg, thr;
	psa_pkg::psa_instr_s instr;
	int num_errors = 0;
	int total_checks = 0;
	psa_core #(.DEPTH(5)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .rom_addr_out(rom_addr),
		.rom_data_in(rom_data), .instr_in(instr), .instr_take_out(take), .irq_req_in(irq_req),
		.irq_ack_out(irq_ack), .file_rd_data_in(frd), .file_wr_out(file_wr),
		.file_wr_addr_out(wr_addr), .file_wr_data_out(wr_data), .status_out(status),
		.rom_pointer_upper_in(pup), .rom_pointer_lower_in(plo), .low_supply_in(lsup),
		.config_word_lvd_in(cfg), .lvd_threshold_out(thr), .watchdog_expiry_in(wdx),
		.power_on_reset_in(por), .low_voltage_reset_in(lvr), .acc_out(acc), .pc_out(pc),
		.page_out(page), .sram_bank_select_out(bank), .stack_count_out(cnt));
	psa_rom rom (.addr_in(rom_addr), .data_out(rom_data));
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic psa_pkg::psa_instr_s mk(input psa_pkg::psa_flow_e f,
		input psa_pkg::psa_alu_e o, input logic [7:0] lit, input logic [10:0] t,
		input logic wf, input logic [6:0] fa);
		psa_pkg::psa_instr_s i;
		i = '0;
		i.flow = f;
		i.op = o;
		i.flags = o inside {psa_pkg::PSA_OP_NONE, psa_pkg::PSA_OP_MOV} ? psa_pkg::PSA_FL_NONE
			: psa_pkg::PSA_FL_ALL;
		i.use_literal = 1'b1;
		i.literal = lit;
		i.target = t;
		i.write_acc = !wf;
		i.write_file = wf;
		i.file_addr = fa;
		return i;
	endfunction
	// hold the instruction until it is taken, bounded against a stuck core
	task automatic ex(input psa_pkg::psa_instr_s i);
		int n;
		n = 0;
		instr = i;
		#1;
		while (take !== 1'b1 && n < 8) begin
			@(negedge clk_in);
			#1;
			n++;
		end
		if (n == 8) chk(16'h0, 16'h1);
		@(negedge clk_in);
	endtask
	task automatic pulse(input logic [2:0] v, input logic [1:0] exp);
		{wdx, por, lvr} = v;
		@(negedge clk_in);
		{wdx, por, lvr} = 3'b000;
		@(negedge clk_in);
		chk(status[4:3], exp);
	endtask
	task automatic stop_test();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		stop_test();
	end
	initial begin
		psa_pkg::psa_instr_s i;
		rstn_in = 1'b0;
		instr = '0;
		{irq_req, lsup, wdx, por, lvr} = 5'h00;
		frd = 8'h0b;
		pup = 3'h2;
		plo = 8'h80;
		cfg = 2'b10;
		repeat (20) @(negedge clk_in);
		rstn_in = 1'b1;
		@(negedge clk_in);
		chk({pc, cnt}, 14'h0000);
		chk({status, acc}, 16'h0000);
		$display("test reset done");
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_MOV, 8'h55, 11'h0, 1'b0, 7'h0));
		chk({pc, acc}, {11'h001, 8'h55});
		i = mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_ADD, 8'h00, 11'h0, 1'b0, 7'h0);
		i.use_literal = 1'b0;
		ex(i);
		chk({acc, status[2:0]}, {8'h60, 3'b010});
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_SUB, 8'h60, 11'h0, 1'b0, 7'h0));
		chk({acc, status[2:0]}, {8'h00, 3'b111});
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_MOV, 8'ha5, 11'h0, 1'b1, 7'h20));
		chk({file_wr, wr_addr, wr_data}, {1'b1, 7'h20, 8'ha5});
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_MOV, 8'hff, 11'h0, 1'b1, 7'h03));
		chk({file_wr, bank, status}, {2'b01, 8'h67});
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_ADD, 8'h00, 11'h0, 1'b1, 7'h03));
		chk(status, 8'h04);
		$display("test alu and status done");
		ex(mk(psa_pkg::PSA_PC_JUMP, psa_pkg::PSA_OP_NONE, 8'h0, 11'h300, 1'b0, 7'h0));
		chk(pc, 11'h300);
		for (int k = 1; k <= 6; k++) begin
			ex(mk(psa_pkg::PSA_PC_CALL, psa_pkg::PSA_OP_NONE, 8'h0, 11'(k * 'h110), 1'b0, 7'h0));
			chk(pc, 11'(k * 'h110));
		end
		chk(cnt, 3'd5);
		for (int k = 5; k >= 1; k--) begin
			ex(mk(psa_pkg::PSA_PC_RET, psa_pkg::PSA_OP_NONE, 8'h0, 11'h0, 1'b0, 7'h0));
			chk(pc, 11'(k * 'h110 + 1));
		end
		ex(mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_MOV, 8'h80, 11'h0, 1'b1, 7'h02));
		chk({page, pc}, {3'h1, 11'h180});
		ex(mk(psa_pkg::PSA_PC_CALL, psa_pkg::PSA_OP_NONE, 8'h0, 11'h205, 1'b0, 7'h0));
		ex(mk(psa_pkg::PSA_PC_LRET, psa_pkg::PSA_OP_MOV, 8'h58, 11'h0, 1'b0, 7'h0));
		chk({pc, acc}, {11'h181, 8'h58});
		$display("test stack done");
		i = mk(psa_pkg::PSA_PC_IRET, psa_pkg::PSA_OP_NONE, 8'h0, 11'h0, 1'b0, 7'h0);
		instr = i;
		irq_req = 1'b1;
		repeat (8) if (irq_ack !== 1'b1) @(negedge clk_in);
		@(negedge clk_in);
		irq_req = 1'b0;
		chk({pc, cnt}, {11'h001, 3'd1});
		ex(i);
		chk({pc, cnt}, {11'h181, 3'd0});
		$display("test interrupt done");
		ex(mk(psa_pkg::PSA_PC_TBL_LO, psa_pkg::PSA_OP_NONE, 8'h0, 11'h0, 1'b0, 7'h0));
		@(negedge clk_in);
		chk(acc, rom.mem[11'h280][7:0]);
		ex(mk(psa_pkg::PSA_PC_TBL_HI, psa_pkg::PSA_OP_NONE, 8'h0, 11'h0, 1'b0, 7'h0));
		@(negedge clk_in);
		chk(acc, {2'b00, rom.mem[11'h280][13:8]});
		ex('0);
		$display("test table read done");
		i = mk(psa_pkg::PSA_PC_SEQ, psa_pkg::PSA_OP_NONE, 8'h0, 11'h0, 1'b0, 7'h0);
		i.sleep = 1'b1;
		pulse(3'b100, 2'b10);
		ex(i);
		chk(status[4:3], 2'b01);
		ex('0);
		pulse(3'b100, 2'b11);
		i.sleep = 1'b0;
		i.watchdog_kick = 1'b1;
		ex(i);
		chk(status[4:3], 2'b00);
		i.watchdog_kick = 1'b0;
		i.sleep = 1'b1;
		ex(i);
		ex('0);
		pulse(3'b010, 2'b00);
		ex(i);
		ex('0);
		pulse(3'b001, 2'b00);
		lsup = 1'b1;
		repeat (2) @(negedge clk_in);
		chk({status[7], thr}, 3'b110);
		lsup = 1'b0;
		$display("test system flags done");
		stop_test();
	end
endmodule
